// [iaa_pkg.sv]
// Constants shared by both ends of the interrupt acknowledge and arbitration link.
package iaa_pkg;
   localparam int          NMOD            = 3;
   localparam int          ARB_W           = 4;
   localparam logic [2:0]  FC_CPU_SPACE    = 3'h7;
   localparam logic [2:0]  FC_IDLE         = 3'h0;
   localparam logic [19:0] ACK_ADDR_HI     = 20'hfffff;
   localparam logic        ACK_ADDR_BIT0   = 1'h1;
   localparam logic [3:0]  SIU_ARB_RST     = 4'hf;
   localparam logic [3:0]  MOD_ARB_RST     = 4'h0;
   localparam logic [3:0]  ARB_NONE        = 4'h0;
   localparam logic [1:0]  ARB_MSB_IDX     = 2'h3;
   localparam logic [1:0]  ARB_LSB_IDX     = 2'h0;
   localparam logic [2:0]  MASK_RST        = 3'h7;
   localparam logic [2:0]  LEVEL_NONE      = 3'h0;
   localparam logic [7:0]  SPURIOUS_VEC    = 8'h18;
   localparam logic [6:0]  BUS_TIMEOUT_CLK = 7'h40;
   localparam int          SR_MASK_LSB     = 8;
   localparam logic [31:0] REG_CTRL        = 32'h0000_0000;
   localparam logic [31:0] REG_STATUS      = 32'h0000_0004;
   localparam logic [31:0] REG_STK_SR      = 32'h0000_0008;
   localparam logic [31:0] REG_STK_PC      = 32'h0000_000c;
   localparam int          CTRL_ARB_LSB    = 0;
   localparam int          CTRL_TLVL_LSB   = 8;
   localparam int          CTRL_TVEC_LSB   = 16;
   localparam logic [2:0]  TICK_LVL_RST    = 3'h0;
   localparam logic [7:0]  TICK_VEC_RST    = 8'h40;
   localparam int          STAT_MASK_LSB   = 8;
   localparam int          STAT_SPUR_BIT   = 11;
   localparam int          STAT_BUSY_BIT   = 12;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [3:0] {
      IAA_IDLE    = 4'h0,
      IAA_STACK   = 4'h1,
      IAA_ACK     = 4'h3,
      IAA_DECODE  = 4'h2,
      IAA_ARB     = 4'h6,
      IAA_RESOLVE = 4'h7,
      IAA_WAITVEC = 4'h5,
      IAA_DONE    = 4'h4,
      IAA_BUS_ERROR_SIGNAL    = 4'hc
   } iaa_state_t;
endpackage

// [iaa_if.sv]
// Link between the processor acknowledge logic and the interrupt requesters.
`timescale 1ns/1ps
interface iaa_if;
   logic [2:0]  fc;
   logic [23:0] ack_addr;
   logic        ack_cycle;
   logic        arb_step;
   logic [1:0]  arb_idx;
   logic        dev_arb_bit;
   logic        mod_arb_bit;
   logic        arb_line;
   logic [2:0]  mod_level;
   logic        mod_match;
   logic [7:0]  vec_data;
   logic        vec_term;
   logic        ext_cycle;
   logic [2:0]  ext_level;
   logic [7:0]  ext_vec;
   logic        ext_term;
   logic        bus_err;

   // Wired-OR contention line.
   assign arb_line = dev_arb_bit | mod_arb_bit;

   modport cpu (
      output fc, ack_addr, ack_cycle, arb_step, arb_idx, dev_arb_bit, ext_cycle, bus_err,
      input  arb_line, mod_level, mod_match, vec_data, vec_term, ext_level, ext_vec, ext_term
   );
   modport req (
      input  fc, ack_addr, ack_cycle, arb_step, arb_idx, arb_line, ext_cycle, bus_err,
      output mod_arb_bit, mod_level, mod_match, vec_data, vec_term, ext_level, ext_vec, ext_term
   );
endinterface

// [iaa_req.sv]
// Requester end: on-chip interrupting modules and one external interrupting device.
`timescale 1ns/1ps
module iaa_req
   import iaa_pkg::*;
(
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   iaa_if.req                              bus,
   input  wire logic                       cfg_we,
   input  wire logic [1:0]                 cfg_idx,
   input  wire logic [3:0]                 cfg_field,
   input  wire logic [NMOD-1:0][2:0]       req_level,
   input  wire logic [NMOD-1:0][7:0]       mod_vector,
   output logic      [NMOD-1:0]            req_ack,
   input  wire logic [2:0]                 ext_req_level,
   input  wire logic [7:0]                 ext_vector,
   input  wire logic                       ext_respond,
   output logic                            ext_ack
);
   logic [NMOD-1:0][3:0] field_q;
   logic [NMOD-1:0]      in_q;
   logic [NMOD-1:0]      win_q;
   logic [NMOD-1:0]      hit;
   logic [NMOD-1:0]      drv;
   logic [NMOD-1:0]      keep;
   logic                 seen_q;
   logic                 last_step;
   logic [2:0]           max_lvl;
   logic [7:0]           win_vec;

   assign last_step = bus.arb_step && (bus.arb_idx == ARB_LSB_IDX);

   genvar i;
   generate
      for (i = 0; i < NMOD; i++) begin : g_mod
         assign hit[i]  = (req_level[i] != LEVEL_NONE) &&
                          (req_level[i] == bus.ack_addr[3:1]);
         assign drv[i]  = in_q[i] && field_q[i][bus.arb_idx];
         assign keep[i] = in_q[i] && !(bus.arb_line && !field_q[i][bus.arb_idx]);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               field_q[i] <= MOD_ARB_RST;
            end else if (cfg_we && (cfg_idx == 2'(i))) begin
               field_q[i] <= cfg_field;
            end
         end
         always_ff @(posedge aclk) begin
            if (!aresetn || !bus.ack_cycle) begin
               in_q[i] <= 1'b0;
            end else if (!seen_q) begin
               in_q[i] <= hit[i];
            end else if (bus.arb_step) begin
               in_q[i] <= keep[i];
            end
         end
         // A winner whose field is zero stays silent so the cycle ends in a bus error.
         always_ff @(posedge aclk) begin
            if (!aresetn || !bus.ack_cycle) begin
               win_q[i]   <= 1'b0;
               req_ack[i] <= 1'b0;
            end else begin
               win_q[i]   <= win_q[i] || (last_step && keep[i] && field_q[i] != ARB_NONE);
               req_ack[i] <= last_step && keep[i] && field_q[i] != ARB_NONE;
            end
         end
      end
   endgenerate

   always_comb begin
      max_lvl = LEVEL_NONE;
      win_vec = 8'h00;
      for (int k = 0; k < NMOD; k++) begin
         if (req_level[k] > max_lvl) begin
            max_lvl = req_level[k];
         end
         if (win_q[k]) begin
            win_vec = mod_vector[k];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen_q          <= 1'b0;
         bus.mod_match   <= 1'b0;
         bus.mod_arb_bit <= 1'b0;
         bus.mod_level   <= LEVEL_NONE;
      end else begin
         seen_q          <= bus.ack_cycle;
         bus.mod_level   <= max_lvl;
         bus.mod_arb_bit <= bus.ack_cycle && (|drv);
         if (!bus.ack_cycle) begin
            bus.mod_match <= 1'b0;
         end else if (!seen_q) begin
            bus.mod_match <= |hit;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !bus.ack_cycle) begin
         bus.vec_term <= 1'b0;
         bus.vec_data <= 8'h00;
      end else if (|win_q) begin
         bus.vec_term <= 1'b1;
         bus.vec_data <= win_vec;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus.ext_level <= LEVEL_NONE;
         bus.ext_term  <= 1'b0;
         bus.ext_vec   <= 8'h00;
         ext_ack       <= 1'b0;
      end else begin
         bus.ext_level <= ext_req_level;
         ext_ack       <= 1'b0;
         if (!bus.ext_cycle) begin
            bus.ext_term <= 1'b0;
         end else if (ext_respond && !bus.ext_term && bus.fc == FC_CPU_SPACE &&
                      ext_req_level == bus.ack_addr[3:1]) begin
            bus.ext_vec  <= ext_vector;
            bus.ext_term <= 1'b1;
            ext_ack      <= 1'b1;
         end
      end
   end
endmodule

// [iaa_cpu.sv]
// Processor end: interrupt acknowledge cycle, contention and spurious handling.
`timescale 1ns/1ps
module iaa_cpu
   import iaa_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   iaa_if.cpu               bus,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        insn_boundary,
   input  wire logic        exc_busy,
   input  wire logic [15:0] sr_in,
   input  wire logic        sr_load,
   input  wire logic [31:0] pc_in,
   input  wire logic        tick_req,
   output logic             int_taken,
   output logic             int_spurious,
   output logic [7:0]       int_vector,
   output logic [2:0]       mask_out
);
   iaa_state_t  state_q;
   iaa_state_t  state_d;
   logic [2:0]  ext_s1_q;
   logic [2:0]  ext_s2_q;
   logic        term_s1_q;
   logic        term_s2_q;
   logic [7:0]  vec_s1_q;
   logic [7:0]  vec_s2_q;
   logic [2:0]  lvl_q;
   logic [2:0]  pend_lvl;
   logic        take;
   logic [1:0]  bit_q;
   logic        phase_q;
   logic        siu_in_q;
   logic        tick_hit_q;
   logic [3:0]  won_q;
   logic [6:0]  tmo_q;
   logic [7:0]  vec_q;
   logic        term;
   logic        in_ack;
   logic [3:0]  siu_field_q;
   logic [2:0]  tick_lvl_q;
   logic [7:0]  tick_vec_q;
   logic [15:0] stk_sr_q;
   logic [31:0] stk_pc_q;
   logic        aw_have_q;
   logic        w_have_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        do_write;

   // External request level and answer come from pins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_s1_q  <= LEVEL_NONE;
         ext_s2_q  <= LEVEL_NONE;
         term_s1_q <= 1'b0;
         term_s2_q <= 1'b0;
         vec_s1_q  <= 8'h00;
         vec_s2_q  <= 8'h00;
      end else begin
         ext_s1_q  <= bus.ext_level;
         ext_s2_q  <= ext_s1_q;
         term_s1_q <= bus.ext_term;
         term_s2_q <= term_s1_q;
         vec_s1_q  <= bus.ext_vec;
         vec_s2_q  <= vec_s1_q;
      end
   end

   always_comb begin
      pend_lvl = bus.mod_level;
      if (ext_s2_q > pend_lvl) begin
         pend_lvl = ext_s2_q;
      end
      if (tick_req && tick_lvl_q > pend_lvl) begin
         pend_lvl = tick_lvl_q;
      end
   end

   assign take = (pend_lvl > mask_out) && insn_boundary && !exc_busy;
   assign term = siu_in_q ? term_s2_q : bus.vec_term;

   always_comb begin
      state_d = state_q;
      case (state_q)
         IAA_IDLE:    if (take) state_d = IAA_STACK;
         IAA_STACK:   state_d = IAA_ACK;
         IAA_ACK:     state_d = IAA_DECODE;
         IAA_DECODE:  state_d = (bus.mod_match || siu_in_q) ? IAA_ARB : IAA_BUS_ERROR_SIGNAL;
         IAA_ARB:     if (phase_q && bit_q == ARB_LSB_IDX) state_d = IAA_RESOLVE;
         IAA_RESOLVE: begin
            if (won_q == ARB_NONE) begin
               state_d = IAA_BUS_ERROR_SIGNAL;
            end else if (siu_in_q && tick_hit_q) begin
               state_d = IAA_DONE;
            end else begin
               state_d = IAA_WAITVEC;
            end
         end
         IAA_WAITVEC: begin
            if (term) begin
               state_d = IAA_DONE;
            end else if (tmo_q == BUS_TIMEOUT_CLK - 7'h01) begin
               state_d = IAA_BUS_ERROR_SIGNAL;
            end
         end
         IAA_DONE:    state_d = IAA_IDLE;
         IAA_BUS_ERROR_SIGNAL:    state_d = IAA_IDLE;
         default:     state_d = IAA_IDLE;
      endcase
   end

   assign in_ack = (state_d == IAA_ACK) || (state_d == IAA_DECODE) || (state_d == IAA_ARB) ||
                   (state_d == IAA_RESOLVE) || (state_d == IAA_WAITVEC);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q       <= IAA_IDLE;
         bus.ack_cycle <= 1'b0;
         bus.fc        <= FC_IDLE;
         bus.ack_addr  <= 24'h000000;
         bus.bus_err   <= 1'b0;
      end else begin
         state_q       <= state_d;
         bus.ack_cycle <= in_ack;
         bus.fc        <= in_ack ? FC_CPU_SPACE : FC_IDLE;
         bus.ack_addr  <= in_ack ? {ACK_ADDR_HI, lvl_q, ACK_ADDR_BIT0} : 24'h000000;
         bus.bus_err   <= (state_d == IAA_BUS_ERROR_SIGNAL);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl_q    <= LEVEL_NONE;
         mask_out <= MASK_RST;
         stk_sr_q <= 16'h0000;
         stk_pc_q <= 32'h0000_0000;
      end else begin
         if (state_q == IAA_IDLE && take) begin
            lvl_q <= pend_lvl;
         end
         if (state_q == IAA_STACK) begin
            stk_sr_q <= {sr_in[15:SR_MASK_LSB+3], mask_out, sr_in[SR_MASK_LSB-1:0]};
            stk_pc_q <= pc_in;
         end
         if (state_q == IAA_ACK) begin
            mask_out <= bus.ack_addr[3:1];
         end else if (sr_load && state_q == IAA_IDLE) begin
            mask_out <= sr_in[SR_MASK_LSB+2:SR_MASK_LSB];
         end
      end
   end

   // System unit contends for tick and external requests at the acknowledged level.
   always_ff @(posedge aclk) begin
      if (!aresetn || state_q == IAA_IDLE) begin
         siu_in_q        <= 1'b0;
         tick_hit_q      <= 1'b0;
         bit_q           <= ARB_MSB_IDX;
         phase_q         <= 1'b0;
         won_q           <= ARB_NONE;
         bus.dev_arb_bit <= 1'b0;
         bus.arb_step    <= 1'b0;
         bus.arb_idx     <= ARB_MSB_IDX;
      end else begin
         if (state_q == IAA_ACK) begin
            tick_hit_q <= tick_req && (tick_lvl_q == lvl_q);
            siu_in_q   <= (tick_req && tick_lvl_q == lvl_q) || (ext_s2_q == lvl_q);
         end
         if (state_q == IAA_ARB) begin
            phase_q <= !phase_q;
            if (phase_q) begin
               bit_q        <= bit_q - 2'h1;
               won_q[bit_q] <= bus.arb_line;
               if (bus.arb_line && !siu_field_q[bit_q]) begin
                  siu_in_q <= 1'b0;
               end
            end
         end
         bus.dev_arb_bit <= (state_q == IAA_ARB) && siu_in_q && siu_field_q[bit_q];
         bus.arb_step    <= (state_q == IAA_ARB) && !phase_q;
         // The requesters register their bit, so the next index is shown one cycle early.
         bus.arb_idx     <= (state_q == IAA_ARB && phase_q) ? bit_q - 2'h1 : bit_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus.ext_cycle <= 1'b0;
         tmo_q         <= 7'h00;
         vec_q         <= 8'h00;
         int_taken     <= 1'b0;
         int_spurious  <= 1'b0;
         int_vector    <= 8'h00;
      end else begin
         bus.ext_cycle <= (state_d == IAA_WAITVEC) && siu_in_q;
         tmo_q         <= (state_q == IAA_WAITVEC) ? tmo_q + 7'h01 : 7'h00;
         if (state_q == IAA_RESOLVE) begin
            vec_q <= tick_vec_q;
         end else if (state_q == IAA_WAITVEC && term) begin
            vec_q <= siu_in_q ? vec_s2_q : bus.vec_data;
         end
         int_taken    <= (state_q == IAA_DONE);
         int_spurious <= (state_q == IAA_BUS_ERROR_SIGNAL);
         if (state_q == IAA_DONE) begin
            int_vector <= vec_q;
         end else if (state_q == IAA_BUS_ERROR_SIGNAL) begin
            int_vector <= SPURIOUS_VEC;
         end
      end
   end

   // AXI4-Lite slave; address and data are taken independently.
   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= 32'h0000_0000;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == REG_CTRL || awaddr_q == REG_STATUS ||
                             awaddr_q == REG_STK_SR || awaddr_q == REG_STK_PC) ?
                            RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         siu_field_q <= SIU_ARB_RST;
         tick_lvl_q  <= TICK_LVL_RST;
         tick_vec_q  <= TICK_VEC_RST;
      end else if (do_write && awaddr_q == REG_CTRL) begin
         if (wstrb_q[0]) siu_field_q <= wdata_q[CTRL_ARB_LSB+3:CTRL_ARB_LSB];
         if (wstrb_q[1]) tick_lvl_q <= wdata_q[CTRL_TLVL_LSB+2:CTRL_TLVL_LSB];
         if (wstrb_q[2]) tick_vec_q <= wdata_q[CTRL_TVEC_LSB+7:CTRL_TVEC_LSB];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         case (s_axi_araddr)
            REG_CTRL: begin
               s_axi_rdata[CTRL_ARB_LSB+3:CTRL_ARB_LSB]   <= siu_field_q;
               s_axi_rdata[CTRL_TLVL_LSB+2:CTRL_TLVL_LSB] <= tick_lvl_q;
               s_axi_rdata[CTRL_TVEC_LSB+7:CTRL_TVEC_LSB] <= tick_vec_q;
            end
            REG_STATUS: begin
               s_axi_rdata[7:0]                           <= int_vector;
               s_axi_rdata[STAT_MASK_LSB+2:STAT_MASK_LSB] <= mask_out;
               s_axi_rdata[STAT_SPUR_BIT]                 <= (int_vector == SPURIOUS_VEC);
               s_axi_rdata[STAT_BUSY_BIT]                 <= (state_q != IAA_IDLE);
            end
            REG_STK_SR: s_axi_rdata[15:0] <= stk_sr_q;
            REG_STK_PC: s_axi_rdata <= stk_pc_q;
            default:    s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// [iaa_link_props.sv]
// Assertions on the acknowledge link between the processor end and the requesters.
`timescale 1ns/1ps
module iaa_link_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [2:0]  fc,
   input wire logic [23:0] ack_addr,
   input wire logic        ack_cycle,
   input wire logic        arb_step,
   input wire logic        ext_cycle,
   input wire logic        vec_term,
   input wire logic        bus_err
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_fc_cpu_space: assert property (ack_cycle |-> fc == 3'h7)
      else $error("function code wrong in acknowledge");
   a_addr_format: assert property (ack_cycle |-> ack_addr[23:4] == 20'hfffff && ack_addr[0])
      else $error("acknowledge address malformed");
   a_level_held: assert property (ack_cycle && $past(ack_cycle) |-> $stable(ack_addr))
      else $error("acknowledged level moved");
   a_arb_always: assert property ($rose(ack_cycle) |-> ##[1:12] (arb_step || bus_err))
      else $error("no contention after acknowledge");
   a_step_in_ack: assert property (arb_step |-> ack_cycle)
      else $error("contention step outside acknowledge");
   a_ext_in_ack: assert property (ext_cycle |-> ack_cycle)
      else $error("external cycle outside acknowledge");
   a_term_in_ack: assert property ($rose(vec_term) |-> ack_cycle)
      else $error("termination outside acknowledge");
   a_bus_error_signal_in_ack: assert property (bus_err |-> $past(ack_cycle))
      else $error("bus error outside acknowledge");
   a_ack_bounded: assert property ($rose(ack_cycle) |-> ##[1:90] !ack_cycle)
      else $error("acknowledge cycle never ended");
endmodule

// [tb_top.sv]
// Self-checking bench for both ends of the acknowledge link.
`timescale 1ns/1ps
module tb_top
   import iaa_pkg::*;
;
   logic                 aclk = 0, aresetn = 0, sr_load = 0, tick_req = 0, cfg_we = 0;
   logic                 insn_boundary = 1, exc_busy = 0, ext_ack;
   logic [NMOD:0]        acks;
   logic                 s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, ext_respond = 0;
   logic                 s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic                 s_axi_bvalid, s_axi_arready, s_axi_rvalid, int_taken, int_spurious;
   logic [31:0]          s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
   logic [1:0]           cfg_idx = 0, s_axi_bresp, s_axi_rresp, rr;
   logic [3:0]           cfg_field = 0;
   logic [15:0]          sr_in = 0;
   logic [2:0]           ext_req_level = 0, mask_out;
   logic [7:0]           ext_vector = 0, int_vector;
   logic [NMOD-1:0][2:0] req_level = 0;
   logic [NMOD-1:0][7:0] mod_vector = {8'h53, 8'h52, 8'h51};
   logic [NMOD-1:0]      req_ack;
   int                   failures = 0, tests_run = 0, hits;

   always #50 aclk = ~aclk;

   iaa_if iaa_if_i ();
   iaa_cpu iaa_cpu_i (.aclk, .aresetn, .bus(iaa_if_i), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .insn_boundary,
      .exc_busy, .sr_in, .sr_load, .pc_in(32'h0000_1000), .tick_req, .int_taken,
      .int_spurious, .int_vector, .mask_out);
   iaa_req iaa_req_i (.aclk, .aresetn, .bus(iaa_if_i), .cfg_we, .cfg_idx, .cfg_field, .req_level,
      .mod_vector, .req_ack, .ext_req_level, .ext_vector, .ext_respond, .ext_ack);
   iaa_link_props iaa_link_props_i (.aclk, .aresetn, .fc(iaa_if_i.fc),
      .ack_addr(iaa_if_i.ack_addr), .ack_cycle(iaa_if_i.ack_cycle), .arb_step(iaa_if_i.arb_step),
      .ext_cycle(iaa_if_i.ext_cycle), .vec_term(iaa_if_i.vec_term), .bus_err(iaa_if_i.bus_err));

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         n++;
      end while (!s_axi_bvalid && n < 50);
      rr = s_axi_bresp;
      if (n >= 50) failures++;
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [31:0] a);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         n++;
      end while (!s_axi_rvalid && n < 50);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      if (n >= 50) failures++;
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask

   task automatic cfg(input logic [1:0] i, input logic [3:0] f);
      cfg_idx <= i;
      cfg_field <= f;
      cfg_we <= 1;
      @(posedge aclk);
      cfg_we <= 0;
      @(posedge aclk);
   endtask

   task automatic mask(input logic [2:0] m);
      sr_in <= {5'h0, m, 8'h0};
      sr_load <= 1;
      @(posedge aclk);
      sr_load <= 0;
      @(posedge aclk);
   endtask

   // Waits for the interrupt outcome, judges it, then withdraws all requests and unmasks.
   task automatic take(input logic [7:0] vec, input logic spur, input logic [2:0] lvl);
      int n = 0;
      acks = '0;
      do begin
         @(posedge aclk);
         acks = acks | {ext_ack, req_ack};
         n++;
      end while (!(int_taken || int_spurious) && n < 300);
      chk({19'h0, ~spur, spur, lvl, vec}, {19'h0, int_taken, int_spurious, mask_out, int_vector});
      req_level <= 0;
      ext_req_level <= 0;
      tick_req <= 0;
      repeat (6) @(posedge aclk);
      mask(3'h0);
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      tally_and_finish();
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      axi_rd(REG_CTRL);
      chk(32'h0040_000f, rd);
      chk(32'h7, {29'h0, mask_out});
      axi_rd(32'h0000_0010);
      chk({30'h0, RESP_SLVERR}, {rd[29:0], rr});
      $display("registers done");
      cfg(2'h0, 4'h3);
      mask(3'h3);
      req_level[0] <= 3'h2;
      hits = 0;
      repeat (60) @(posedge aclk) if (int_taken || int_spurious) hits++;
      chk(0, hits);
      insn_boundary <= 0;
      mask(3'h1);
      repeat (20) @(posedge aclk) if (int_taken || int_spurious) hits++;
      insn_boundary <= 1;
      exc_busy <= 1;
      repeat (20) @(posedge aclk) if (int_taken || int_spurious) hits++;
      exc_busy <= 0;
      chk(0, hits);
      take(8'h51, 1'h0, 3'h2);
      chk(4'h1, acks);
      axi_rd(REG_STK_PC);
      chk(32'h0000_1000, rd);
      axi_rd(REG_STK_SR);
      chk(32'h0000_0100, rd);
      req_level[0] <= 3'h3;
      @(posedge aclk);
      req_level[0] <= 3'h0;
      take(8'h18, 1'h1, 3'h3);
      $display("mask done");
      cfg(2'h1, 4'h9);
      cfg(2'h2, 4'h8);
      req_level <= {3'h4, 3'h4, 3'h4};
      take(8'h52, 1'h0, 3'h4);
      chk(4'h2, acks);
      $display("contention done");
      cfg(2'h2, 4'h0);
      req_level[2] <= 3'h5;
      take(8'h18, 1'h1, 3'h5);
      $display("zero field done");
      ext_req_level <= 3'h6;
      ext_vector <= 8'h77;
      ext_respond <= 1;
      take(8'h77, 1'h0, 3'h6);
      chk(4'h8, acks);
      ext_respond <= 0;
      ext_req_level <= 3'h6;
      take(8'h18, 1'h1, 3'h6);
      $display("external done");
      axi_wr(REG_CTRL, 32'h0066_030f);
      chk({30'h0, RESP_OKAY}, {30'h0, rr});
      ext_respond <= 1;
      ext_req_level <= 3'h3;
      tick_req <= 1;
      take(8'h66, 1'h0, 3'h3);
      axi_wr(REG_CTRL, 32'h0066_0002);
      ext_req_level <= 3'h2;
      req_level[1] <= 3'h2;
      take(8'h52, 1'h0, 3'h2);
      $display("tick and system field done");
      tally_and_finish();
   end
endmodule
